// file: common/siom_pkg.sv
// Purpose: constants for the servo I/O function mapper
// Assumes: 32-bit AHB-Lite register bus, 250 MHz system clock
// Notes: register offsets are byte addresses, one word each
package siom_pkg;
	localparam int unsigned CLK_MHZ = 250;
	localparam int unsigned DONE_DELAY_MAX_MS = 200;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned DONE_DELAY_MAX_CYC = DONE_DELAY_MAX_MS * CYC_PER_MS;
	localparam logic [7:0] DONE_DELAY_RST = 8'h00;

	localparam logic [7:0] OFS_FORCE_A = 8'h00;
	localparam logic [7:0] OFS_FORCE_B = 8'h04;
	localparam logic [7:0] OFS_FORCE_C = 8'h08;
	localparam logic [7:0] OFS_FORCE_D = 8'h0C;
	localparam logic [7:0] OFS_FORCE_E = 8'h10;
	localparam logic [7:0] OFS_IN_ASSIGN = 8'h14;
	localparam logic [7:0] OFS_OUT_ASSIGN = 8'h18;
	localparam logic [7:0] OFS_DONE_DELAY = 8'h1C;
	localparam logic [7:0] OFS_POLARITY = 8'h20;
	localparam logic [7:0] OFS_FUNC_STATE = 8'h24;
	localparam logic [7:0] OFS_OUT_STATE = 8'h28;

	localparam logic [7:0] FORCE_RST = 8'h00;
	localparam logic [31:0] ASSIGN_RST = 32'h0000_0000;
	localparam logic [31:0] OUT_ASSIGN_RST = 32'h0000_0000;
	localparam logic [1:0] POLARITY_RST = 2'h0;

	// mask of used bits per force word
	localparam logic [7:0] FORCE_MASK_A = 8'hFF;
	localparam logic [7:0] FORCE_MASK_B = 8'hB7;
	localparam logic [7:0] FORCE_MASK_C = 8'h7E;
	localparam logic [7:0] FORCE_MASK_D = 8'h7C;
	localparam logic [7:0] FORCE_MASK_E = 8'h03;

	typedef enum logic [4:0] {
		FN_ALWAYS = 5'h01, FN_READY = 5'h02, FN_FAULT_FREE = 5'h03,
		FN_ZERO_SPEED = 5'h04, FN_IN_POS = 5'h05, FN_SPD_REACH = 5'h06,
		FN_TRQ_REACH = 5'h07, FN_BRAKE = 5'h08, FN_RUNNING = 5'h09,
		FN_NEAR_POS = 5'h0A, FN_TRQ_LIMIT = 5'h0B, FN_SPD_LIMIT = 5'h0C,
		FN_SPD_MATCH = 5'h0D, FN_HOME_DONE = 5'h0F, FN_TGT_DONE = 5'h10,
		FN_INDEX = 5'h12
	} siom_func_t;

	typedef enum logic [1:0] {
		DLY_IDLE = 2'b00, DLY_WAIT = 2'b01, DLY_DONE = 2'b10
	} siom_dly_t;
endpackage

// file: rtl/siom_mapper.sv
// Purpose: servo drive digital output function select and input function force logic
// Assumes: status inputs synchronous to SYS_CLK except terminals, index pulse
// Notes: 4 input terminals, 4 output terminals, one select byte per terminal (5-bit output code, input index below 40)
module siom_mapper import siom_pkg::*; #(
	parameter int unsigned N_IN = 4,
	parameter int unsigned N_OUT = 4,
	parameter int unsigned W = 16,
	parameter int unsigned DELAY_MS_MAX = DONE_DELAY_MAX_MS,
	parameter int unsigned CYC_MS = CYC_PER_MS
) (
	// clock and reset
	input  wire logic             SYS_CLK,
	input  wire logic             RST,
	// AHB-Lite slave
	input  wire logic             HSEL,
	input  wire logic [31:0]      HADDR,
	input  wire logic [1:0]       HTRANS,
	input  wire logic             HWRITE,
	input  wire logic [2:0]       HSIZE,
	input  wire logic [31:0]      HWDATA,
	input  wire logic             HREADY,
	output logic      [31:0]      HRDATA,
	output logic                  HREADYOUT,
	output logic                  HRESP,
	// drive status
	input  wire logic             MAIN_POWER_OK,
	input  wire logic             ALARM_ACTIVE,
	input  wire logic             POS_MODE,
	input  wire logic             TRQ_MODE,
	input  wire logic [W-1:0]     MOTOR_SPEED,
	input  wire logic [W-1:0]     CMD_SPEED,
	input  wire logic [W-1:0]     MOTOR_TORQUE,
	input  wire logic [W-1:0]     POS_DEVIATION,
	input  wire logic [W-1:0]     ZERO_SPEED_THRESHOLD,
	input  wire logic [W-1:0]     IN_POSITION_WINDOW,
	input  wire logic [W-1:0]     ARRIVAL_SPEED_THRESHOLD,
	input  wire logic [W-1:0]     ARRIVAL_TORQUE_THRESHOLD,
	input  wire logic [W-1:0]     NEAR_POSITION_WINDOW,
	input  wire logic [W-1:0]     SPEED_LIMIT_VALUE,
	input  wire logic [W-1:0]     SPEED_MATCH_WINDOW,
	input  wire logic             TORQUE_AT_LIMIT,
	input  wire logic             BRAKE_RELEASE,
	input  wire logic             MOTOR_EXCITED,
	input  wire logic             HOMING_DONE,
	input  wire logic             TARGET_MOVE_END,
	input  wire logic             INDEX_PULSE,
	// terminals
	input  wire logic [N_IN-1:0]  IN_TERM,
	output logic      [N_OUT-1:0] OUT_TERM,
	output logic      [39:0]      INPUT_FUNC
);
	// speed and torque magnitudes arrive signed two's complement
	logic [W-1:0]  spd_abs, trq_abs, dev_abs, spd_err;
	logic [W-1:0]  spd_diff;

	// registers
	logic [7:0]    force_a, force_b, force_c, force_d, force_e;
	logic [31:0]   in_assign, out_assign;
	logic [7:0]    done_delay;
	logic [1:0]    polarity;
	logic [7:0]    next_force_a, next_force_b, next_force_c, next_force_d, next_force_e;
	logic [31:0]   next_in_assign, next_out_assign;
	logic [7:0]    next_done_delay;
	logic [1:0]    next_polarity;
	// bus pipeline
	logic          dp_wr;
	logic [7:0]    dp_addr;
	logic          next_dp_wr, next_dp_rd;
	logic [7:0]    next_dp_addr;
	logic [31:0]   rdata, next_rdata;
	// synchronisers
	logic [N_IN-1:0] term_s1, term_s2;
	logic          idx_s1, idx_s2;
	// delay
	siom_dly_t     dly_st, next_dly_st;
	logic [31:0]   dly_cnt, next_dly_cnt;
	logic [31:0]   dly_target;
	logic          tgt_done;
	// functions
	logic [39:0]   force_all, assigned, term_level, next_func, func;
	logic [31:0]   flags;
	logic [N_OUT-1:0] next_out;

	function automatic logic [W-1:0] absv(input logic [W-1:0] v);
		absv = v[W-1] ? W'(-v) : v;
	endfunction

	assign spd_abs  = absv(MOTOR_SPEED);
	assign trq_abs  = absv(MOTOR_TORQUE);
	assign dev_abs  = absv(POS_DEVIATION);
	assign spd_diff = MOTOR_SPEED - CMD_SPEED;
	assign spd_err  = absv(spd_diff);

	// two flops on pins before any use
	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			term_s1 <= '0;
			term_s2 <= '0;
			idx_s1  <= 1'b0;
			idx_s2  <= 1'b0;
		end else begin
			term_s1 <= IN_TERM;
			term_s2 <= term_s1;
			idx_s1  <= INDEX_PULSE;
			idx_s2  <= idx_s1;
		end
	end

	// register file, zero wait states
	always_comb begin
		next_dp_wr = HSEL && HREADY && HTRANS[1] && HWRITE;
		next_dp_rd = HSEL && HREADY && HTRANS[1] && !HWRITE;
		next_dp_addr = (HSEL && HREADY && HTRANS[1]) ? HADDR[7:0] : dp_addr;
		next_force_a = force_a;
		next_force_b = force_b;
		next_force_c = force_c;
		next_force_d = force_d;
		next_force_e = force_e;
		next_in_assign = in_assign;
		next_out_assign = out_assign;
		next_done_delay = done_delay;
		next_polarity = polarity;
		if (dp_wr) begin
			case (dp_addr)
				OFS_FORCE_A: next_force_a = HWDATA[7:0] & FORCE_MASK_A;
				OFS_FORCE_B: next_force_b = HWDATA[7:0] & FORCE_MASK_B;
				OFS_FORCE_C: next_force_c = HWDATA[7:0] & FORCE_MASK_C;
				OFS_FORCE_D: next_force_d = HWDATA[7:0] & FORCE_MASK_D;
				OFS_FORCE_E: next_force_e = HWDATA[7:0] & FORCE_MASK_E;
				OFS_IN_ASSIGN: next_in_assign = HWDATA;
				OFS_OUT_ASSIGN: next_out_assign = HWDATA;
				// values above the max clamp so the delay never exceeds 200 ms
				OFS_DONE_DELAY: next_done_delay = (HWDATA[7:0] > 8'(DELAY_MS_MAX)) ?
					8'(DELAY_MS_MAX) : HWDATA[7:0];
				OFS_POLARITY: next_polarity = HWDATA[1:0];
				default: ;
			endcase
		end
		next_rdata = 32'h0000_0000;
		if (next_dp_rd) begin
			case (HADDR[7:0])
				OFS_FORCE_A: next_rdata = {24'h000000, force_a};
				OFS_FORCE_B: next_rdata = {24'h000000, force_b};
				OFS_FORCE_C: next_rdata = {24'h000000, force_c};
				OFS_FORCE_D: next_rdata = {24'h000000, force_d};
				OFS_FORCE_E: next_rdata = {24'h000000, force_e};
				OFS_IN_ASSIGN: next_rdata = in_assign;
				OFS_OUT_ASSIGN: next_rdata = out_assign;
				OFS_DONE_DELAY: next_rdata = {24'h000000, done_delay};
				OFS_POLARITY: next_rdata = {30'h0, polarity};
				OFS_FUNC_STATE: next_rdata = func[31:0];
				OFS_OUT_STATE: next_rdata = {func[39:32], 20'h00000, OUT_TERM};
				default: next_rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			dp_wr <= 1'b0;
			dp_addr <= 8'h00;
			rdata <= 32'h0000_0000;
			force_a <= FORCE_RST;
			force_b <= FORCE_RST;
			force_c <= FORCE_RST;
			force_d <= FORCE_RST;
			force_e <= FORCE_RST;
			in_assign <= ASSIGN_RST;
			out_assign <= OUT_ASSIGN_RST;
			done_delay <= DONE_DELAY_RST;
			polarity <= POLARITY_RST;
		end else begin
			dp_wr <= next_dp_wr;
			dp_addr <= next_dp_addr;
			rdata <= next_rdata;
			force_a <= next_force_a;
			force_b <= next_force_b;
			force_c <= next_force_c;
			force_d <= next_force_d;
			force_e <= next_force_e;
			in_assign <= next_in_assign;
			out_assign <= next_out_assign;
			done_delay <= next_done_delay;
			polarity <= next_polarity;
		end
	end

	assign HRDATA = rdata;
	assign HREADYOUT = 1'b1;
	assign HRESP = 1'b0;

	// input functions: index = word*8 + bit; in_assign byte k selects for terminal k
	assign force_all = {force_e, force_d, force_c, force_b, force_a};
	always_comb begin
		assigned = '0;
		term_level = '0;
		for (int k = 0; k < N_IN; k++) begin
			if (in_assign[k*8 +: 8] < 8'd40) begin
				assigned[in_assign[k*8 +: 6]] = 1'b1;
				term_level[in_assign[k*8 +: 6]] = term_level[in_assign[k*8 +: 6]] | term_s2[k];
			end
		end
		// unassigned functions see no terminal, so only the force bit counts
		next_func = force_all | (term_level & assigned);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			func <= '0;
		else
			func <= next_func;
	end
	assign INPUT_FUNC = func;

	// target done delay; counts from the move end, restarts on a new move
	assign dly_target = 32'(done_delay) * 32'(CYC_MS);
	always_comb begin
		next_dly_st = dly_st;
		next_dly_cnt = dly_cnt;
		case (dly_st)
			DLY_IDLE: begin
				next_dly_cnt = 32'h0000_0000;
				if (TARGET_MOVE_END)
					next_dly_st = (done_delay == 8'h00) ? DLY_DONE : DLY_WAIT;
			end
			DLY_WAIT: begin
				if (!TARGET_MOVE_END) begin
					next_dly_st = DLY_IDLE;
				end else if (dly_cnt + 32'h1 >= dly_target) begin
					next_dly_st = DLY_DONE;
				end else begin
					next_dly_cnt = dly_cnt + 32'h1;
				end
			end
			DLY_DONE: if (!TARGET_MOVE_END) next_dly_st = DLY_IDLE;
			default: next_dly_st = DLY_IDLE;
		endcase
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST) begin
			dly_st <= DLY_IDLE;
			dly_cnt <= 32'h0000_0000;
		end else begin
			dly_st <= next_dly_st;
			dly_cnt <= next_dly_cnt;
		end
	end
	assign tgt_done = (dly_st == DLY_DONE);

	// status flags indexed by function code
	always_comb begin
		flags = '0;
		flags[FN_ALWAYS] = 1'b1;
		flags[FN_READY] = MAIN_POWER_OK && !ALARM_ACTIVE;
		flags[FN_FAULT_FREE] = !ALARM_ACTIVE;
		flags[FN_ZERO_SPEED] = !POS_MODE && !(spd_abs > ZERO_SPEED_THRESHOLD);
		flags[FN_IN_POS] = POS_MODE && !(dev_abs > IN_POSITION_WINDOW);
		flags[FN_SPD_REACH] = !POS_MODE && ((spd_abs > ARRIVAL_SPEED_THRESHOLD) ^ polarity[0]);
		flags[FN_TRQ_REACH] = (trq_abs > ARRIVAL_TORQUE_THRESHOLD) ^ polarity[1];
		flags[FN_BRAKE] = BRAKE_RELEASE;
		flags[FN_RUNNING] = MOTOR_EXCITED;
		flags[FN_NEAR_POS] = POS_MODE && (dev_abs < NEAR_POSITION_WINDOW);
		flags[FN_TRQ_LIMIT] = TORQUE_AT_LIMIT;
		flags[FN_SPD_LIMIT] = TRQ_MODE && (spd_abs >= SPEED_LIMIT_VALUE);
		flags[FN_SPD_MATCH] = spd_err < SPEED_MATCH_WINDOW;
		flags[FN_HOME_DONE] = HOMING_DONE;
		flags[FN_TGT_DONE] = tgt_done;
		flags[FN_INDEX] = idx_s2;
		for (int j = 0; j < N_OUT; j++)
			next_out[j] = flags[out_assign[j*8 +: 5]] && (out_assign[j*8+5 +: 3] == 3'h0);
	end

	always_ff @(posedge SYS_CLK) begin
		if (RST)
			OUT_TERM <= '0;
		else
			OUT_TERM <= next_out;
	end

	AST_READY: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h02 && !MAIN_POWER_OK) |=> !OUT_TERM[0])
		else $error("ready output high without main power");
	AST_FAULT: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h03 && $stable(out_assign)) |=> (OUT_TERM[0] == !$past(ALARM_ACTIVE)))
		else $error("fault-free output disagrees with alarm");
	AST_ZSPEED: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h04 && spd_abs > ZERO_SPEED_THRESHOLD) |=> !OUT_TERM[0])
		else $error("zero speed output high while moving");
	AST_INPOS: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h05 && POS_MODE && dev_abs <= IN_POSITION_WINDOW) |=> OUT_TERM[0])
		else $error("in-position output low inside window");
	AST_NEAR: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0A && dev_abs > NEAR_POSITION_WINDOW) |=> !OUT_TERM[0])
		else $error("near output high outside window");
	AST_UNKNOWN: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0E) |=> !OUT_TERM[0])
		else $error("unknown code drives output high");
	AST_FORCE: assert property (@(posedge SYS_CLK) disable iff (RST)
		force_a[0] |=> func[0])
		else $error("forced function not active");
	AST_UNASSIGNED: assert property (@(posedge SYS_CLK) disable iff (RST)
		(!force_b[1] && !assigned[9]) |=> !func[9])
		else $error("unassigned function active");
	AST_DONE_ZERO: assert property (@(posedge SYS_CLK) disable iff (RST)
		(dly_st == DLY_IDLE && TARGET_MOVE_END && done_delay == 8'h00) |=> ##0 tgt_done)
		else $error("done not set with zero delay");
	AST_DONE_EARLY: assert property (@(posedge SYS_CLK) disable iff (RST)
		(dly_st == DLY_WAIT) |-> (dly_cnt < dly_target))
		else $error("done delay overran");

	// terminal 0 watched per code; the other terminals share the same decode
	AST_READY_HI: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h02 && MAIN_POWER_OK && !ALARM_ACTIVE) |=> OUT_TERM[0])
		else $error("ready output low while healthy");
	AST_ALARM_LO: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h03 && ALARM_ACTIVE) |=> !OUT_TERM[0])
		else $error("fault-free output high during alarm");
	AST_SPD_REACH: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h06 && !POS_MODE && ((spd_abs > ARRIVAL_SPEED_THRESHOLD) != polarity[0])) |=> OUT_TERM[0])
		else $error("speed arrival output not asserted");
	AST_TRQ_REACH: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h07 && ((trq_abs > ARRIVAL_TORQUE_THRESHOLD) == polarity[1])) |=> !OUT_TERM[0])
		else $error("torque arrival output wrongly asserted");
	AST_BRAKE: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h08 && BRAKE_RELEASE) |=> OUT_TERM[0])
		else $error("brake output low while releasing");
	AST_RUN: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h09 && !MOTOR_EXCITED) |=> !OUT_TERM[0])
		else $error("running output high while not excited");
	AST_TRQ_LIMIT: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0B && TORQUE_AT_LIMIT) |=> OUT_TERM[0])
		else $error("torque limit output low at limit");
	AST_SPD_LIMIT: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0C && TRQ_MODE && spd_abs >= SPEED_LIMIT_VALUE) |=> OUT_TERM[0])
		else $error("speed limit output low at limit");
	AST_SPD_MATCH: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0D && spd_err > SPEED_MATCH_WINDOW) |=> !OUT_TERM[0])
		else $error("speed match output high outside window");
	AST_HOME: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h0F && !HOMING_DONE) |=> !OUT_TERM[0])
		else $error("homing output high before completion");
	AST_TGT_IDLE: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h10 && dly_st == DLY_IDLE) |=> !OUT_TERM[0])
		else $error("target done output high without move end");
	AST_INDEX: assert property (@(posedge SYS_CLK) disable iff (RST)
		(out_assign[7:0] == 8'h12 && idx_s2) |=> OUT_TERM[0])
		else $error("index output low while pulse valid");
	AST_FORCE_MASK: assert property (@(posedge SYS_CLK) disable iff (RST)
		((force_all & ~{FORCE_MASK_E, FORCE_MASK_D, FORCE_MASK_C, FORCE_MASK_B, FORCE_MASK_A}) == 40'h0000000000))
		else $error("unused force bit set");
	AST_TERM_FOLLOW: assert property (@(posedge SYS_CLK) disable iff (RST)
		(in_assign[7:0] == 8'h00 && term_s2[0]) |=> func[0])
		else $error("assigned function does not follow terminal");
endmodule

// file: test/servo_io_function_mapper_tb.sv
// Purpose: self-checking bench for the servo I/O function mapper
// Assumes: CYC_MS shortened to 10 cycles per ms
// Notes: pin checks at the falling edge, bus read data at the rising edge that ends its phase
module servo_io_function_mapper_tb import siom_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, rst, hsel, hwrite, pw, al, pm, tm, tal, brake_release_out, exc, hom, tme, idx, hreadyout, hresp;
	logic [1:0]  htrans, pol;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [15:0] spd, cmd, trq, dev, zst, inw, ast, att, nrw, lim, smw;
	logic [3:0]  want, in_term, out_term, seen;
	logic [39:0] in_func, fmv;
	logic [7:0]  fm [5];
	logic [7:0]  codes [21];
	logic [7:0]  sel [4];
	logic [7:0]  v;
	int          bad_count, cmp_count, k, n;

	siom_mapper #(.CYC_MS(10)) u_siom_mapper (.SYS_CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr),
		.HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'b010), .HWDATA(hwdata), .HREADY(hreadyout),
		.HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .MAIN_POWER_OK(pw), .ALARM_ACTIVE(al),
		.POS_MODE(pm), .TRQ_MODE(tm), .MOTOR_SPEED(spd), .CMD_SPEED(cmd), .MOTOR_TORQUE(trq),
		.POS_DEVIATION(dev), .ZERO_SPEED_THRESHOLD(zst), .IN_POSITION_WINDOW(inw),
		.ARRIVAL_SPEED_THRESHOLD(ast), .ARRIVAL_TORQUE_THRESHOLD(att), .NEAR_POSITION_WINDOW(nrw),
		.SPEED_LIMIT_VALUE(lim), .SPEED_MATCH_WINDOW(smw), .TORQUE_AT_LIMIT(tal), .BRAKE_RELEASE(brake_release_out),
		.MOTOR_EXCITED(exc), .HOMING_DONE(hom), .TARGET_MOVE_END(tme), .INDEX_PULSE(idx),
		.IN_TERM(in_term), .OUT_TERM(out_term), .INPUT_FUNC(in_func));
	siom_host_model u_siom_host_model (.clk(clk), .want(want), .out_term(out_term), .in_term(in_term),
		.seen(seen));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [39:0] got, input logic [39:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// each phase held until hready is seen high at a rising edge; read data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h0, a};
		hwrite <= wr;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (hreadyout !== 1'b1) @(posedge clk);
		q = hrdata;
	endtask

	task automatic settle(input int c);
		repeat (c) @(posedge clk);
		@(negedge clk);
	endtask

	task automatic wait_hi();
		n = 0;
		while (out_term[0] !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
	endtask

	function automatic logic [15:0] mag(input logic [15:0] x);
		return x[15] ? 16'(-x) : x;
	endfunction

	function automatic logic exp_out(input logic [7:0] c);
		case (c)
			8'h01: return 1'b1;
			8'h02: return pw & ~al;
			8'h03: return ~al;
			8'h04: return !(mag(spd) > zst);
			8'h05: return !(mag(dev) > inw);
			8'h06: return (mag(spd) > ast) ^ pol[0];
			8'h07: return (mag(trq) > att) ^ pol[1];
			8'h08: return brake_release_out;
			8'h09: return exc;
			8'h0A: return mag(dev) < nrw;
			8'h0B: return tal;
			8'h0C: return mag(spd) >= lim;
			8'h0D: return mag(16'(spd - cmd)) < smw;
			8'h0F: return hom;
			8'h12: return idx;
			default: return 1'b0;
		endcase
	endfunction

	// speed, position and torque-mode codes only count in their own mode
	function automatic logic mode_ok(input logic [7:0] c);
		return ((c == 8'h04 || c == 8'h06) ? !pm : 1'b1) && ((c == 8'h05 || c == 8'h0A) ? pm : 1'b1)
			&& (c != 8'h0C || tm);
	endfunction

	function automatic logic [15:0] sr();
		return 16'($urandom_range(0, 16382)) - 16'd8191;
	endfunction

	initial begin
		#200000;
		bad_count++;
		summarize();
	end

	initial begin
		{rst, hsel, hwrite, pw, al, pm, tm, tal, brake_release_out, exc, hom, tme, idx} = 13'h1000;
		{htrans, pol, haddr, hwdata, want} = '0;
		{spd, cmd, trq, dev, zst, inw, ast, att, nrw, lim, smw} = '0;
		fm = '{FORCE_MASK_A, FORCE_MASK_B, FORCE_MASK_C, FORCE_MASK_D, FORCE_MASK_E};
		fmv = {FORCE_MASK_E, FORCE_MASK_D, FORCE_MASK_C, FORCE_MASK_B, FORCE_MASK_A};
		codes = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C,
			8'h0D, 8'h0F, 8'h12, 8'h00, 8'h0E, 8'h11, 8'h13, 8'h1F, 8'h40};
		void'($urandom(32'h9effdc40));
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 12; i++) begin
			bus(1'b0, i < 11 ? 8'(i * 4) : 8'h40, 32'h0);
			chk(40'(q), 40'h0);
			chk(40'({hresp, hreadyout}), 40'h1);
		end
		chk(40'(out_term), 40'h0);
		$display("test reset_values done");
		for (int p = 0; p < 2; p++) begin
			for (int w = 0; w < 5; w++) begin
				v = p ? 8'($urandom_range(0, 255)) : 8'hFF;
				bus(1'b1, 8'(w * 4), {24'h0, v});
				bus(1'b0, 8'(w * 4), 32'h0);
				chk(40'(q), 40'(fm[w] & v));
			end
			if (p == 0) begin
				settle(1);
				chk(in_func, fmv);
				bus(1'b0, OFS_FUNC_STATE, 32'h0);
				chk(40'(q), 40'(fmv[31:0]));
			end
		end
		for (int w = 0; w < 5; w++) bus(1'b1, 8'(w * 4), 32'h0);
		$display("test force_words done");
		for (int t = 0; t < 4; t++) begin
			do k = $urandom_range(0, 39); while (fmv[k] == 1'b0);
			bus(1'b1, OFS_IN_ASSIGN, {16'h2828, 8'(k), 8'(k)});
			@(posedge clk);
			want <= 4'b1110;
			settle(6);
			chk(in_func, 40'h1 << k);
			@(posedge clk);
			want <= 4'b1100;
			settle(6);
			chk(in_func, 40'h0);
			bus(1'b1, 8'((k / 8) * 4), 32'(1 << (k % 8)));
			settle(2);
			chk(in_func, 40'h1 << k);
			bus(1'b1, 8'((k / 8) * 4), 32'h0);
		end
		$display("test terminals done");
		repeat (40) begin
			for (int j = 0; j < 4; j++) sel[j] = codes[$urandom_range(0, 20)];
			pol = 2'($urandom_range(0, 3));
			bus(1'b1, OFS_POLARITY, {30'h0, pol});
			bus(1'b1, OFS_OUT_ASSIGN, {sel[3], sel[2], sel[1], sel[0]});
			@(posedge clk);
			{pw, al, pm, tm, tal, brake_release_out, exc, hom, idx} <= 9'($urandom_range(0, 511));
			{spd, cmd, trq, dev} <= {sr(), sr(), sr(), sr()};
			{zst, inw, ast, att} <= {4{16'($urandom_range(0, 8191))}};
			{nrw, lim, smw} <= {16'($urandom_range(0, 8191)), 16'($urandom_range(0, 8191)), sr() & 16'h1FFF};
			settle(6);
			for (int j = 0; j < 4; j++)
				if (mode_ok(sel[j])) chk(40'(seen[j]), 40'(exp_out(sel[j])));
		end
		$display("test output_codes done");
		bus(1'b1, OFS_OUT_ASSIGN, 32'h10);
		@(posedge clk);
		tme <= 1'b1;
		@(negedge clk);
		wait_hi();
		chk(40'(n <= 3), 40'h1);
		@(posedge clk);
		tme <= 1'b0;
		settle(2);
		chk(40'(out_term[0]), 40'h0);
		bus(1'b1, OFS_DONE_DELAY, 32'hFF);
		bus(1'b0, OFS_DONE_DELAY, 32'h0);
		chk(40'(q), 40'hC8);
		bus(1'b1, OFS_DONE_DELAY, 32'h2);
		@(posedge clk);
		tme <= 1'b1;
		@(negedge clk);
		wait_hi();
		chk(40'(n >= 18 && n <= 23), 40'h1);
		@(posedge clk);
		tme <= 1'b0;
		$display("test done_delay done");
		bus(1'b1, OFS_OUT_ASSIGN, 32'h01010101);
		bus(1'b1, OFS_FORCE_A, 32'hFF);
		settle(2);
		chk(40'(out_term), 40'hF);
		@(posedge clk);
		rst <= 1'b1;
		settle(2);
		chk({in_func[35:0], out_term}, 40'h0);
		chk(40'(in_func[39:36]), 40'h0);
		@(posedge clk);
		rst <= 1'b0;
		bus(1'b0, OFS_OUT_ASSIGN, 32'h0);
		chk(40'(q), 40'h0);
		$display("test mid_reset done");
		summarize();
	end
endmodule

// file: test/siom_host_model.sv
// Purpose: host controller model wired to the I/O terminals
// Assumes: terminals are plain levels, high = on
// Notes: input changes land off the clock edge, like a real wire
module siom_host_model (
	// clock for sampling outputs
	input  wire logic       clk,
	// levels the host wants on the inputs
	input  wire logic [3:0] want,
	input  wire logic [3:0] out_term,
	// wired side
	output logic      [3:0] in_term,
	output logic      [3:0] seen
);
	timeunit 1ns;
	timeprecision 100ps;
	initial in_term = 4'h0;
	// skewed so the design's synchroniser really sees an asynchronous edge
	always @(want) in_term <= #1.3 want;
	always @(posedge clk) seen <= out_term;
endmodule
